// [dv/lcdc_decode_tb_top.sv]
// lcdc_decode_tb_top: self-checking bench of the command decoder
// assumes: lcdc_pkg compiled first, host model drives the command port
`timescale 1ns/1ns
`default_nettype none
module lcdc_decode_tb_top
  import lcdc_pkg::*;
;
  logic ref_clk, rst, ext_clk_sel, cmd_valid, cmd_is_data;
  logic osc_enable, lcd_outputs_off, bias_gen_en, vlcd_gen_en, charge_pump_en;
  logic [7:0] cmd_byte, r;
  logic [6:0] scan_row, col_addr, drv_row, rc;
  logic [3:0] bank_addr, rb;
  logic [2:0] mult_factor, bias_n;
  lcdc_cfg_t cfg;
  lcdc_mode_t disp_mode;
  lcdc_ramwr_t ram_wr;
  integer seed, mismatches, total_checks, i, j;
  lcdc_decode u_dut (.ref_clk, .rst, .cmd_valid, .cmd_is_data, .cmd_byte, .ext_clk_sel,
    .scan_row, .cfg, .disp_mode, .ram_wr, .bank_addr, .col_addr, .drv_row, .osc_enable,
    .lcd_outputs_off, .bias_gen_en, .vlcd_gen_en, .charge_pump_en, .mult_factor, .bias_n);
  lcdc_host_model u_host (.ref_clk, .cmd_valid, .cmd_is_data, .cmd_byte);
  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  function automatic lcdc_mode_t exp_mode(input logic [1:0] de);
    case (de)
      2'h0: exp_mode = LCDC_BLANK;
      2'h2: exp_mode = LCDC_NORMAL;
      2'h1: exp_mode = LCDC_ALL_ON;
      default: exp_mode = LCDC_INVERSE;
    endcase
  endfunction
  // vertical mirror first, then the pad block reversals
  function automatic logic [6:0] exp_row(input logic [6:0] row, input logic y, input logic t,
    input logic b);
    logic [6:0] v;
    v = y ? 7'h40 - row : row;
    exp_row = v;
    if (t && v >= 7'h13 && v <= 7'h20) exp_row = 7'h33 - v;
    else if (t && v >= 7'h33) exp_row = 7'h73 - v;
    else if (b && v <= 7'h12) exp_row = 7'h12 - v;
    else if (b && v >= 7'h21 && v <= 7'h32) exp_row = 7'h53 - v;
  endfunction
  // one data write, then compare the strobe fields against bank, column, data and the bank 8 mask
  task automatic wr_chk(input logic [3:0] b, input logic [6:0] c, input logic [7:0] d);
    u_host.send(1'b1, d);
    chk("wr_at", {1'b1, b, c}, {ram_wr.wr_en, ram_wr.bank, ram_wr.col});
    chk("wr_data", d, ram_wr.data);
    chk("wr_mask", (b == 4'h8) ? 8'h80 : 8'hff, ram_wr.mask);
  endtask
  // every visible field except lsb_on_top and the write bank, column, data and mask against its reset value
  task automatic chk_reset();
    chk("sleep", 1, cfg.sleep_flag);
    chk("cfg", 0, {cfg.addr_vertical, cfg.ext_page, cfg.column_flip, cfg.row_flip,
      cfg.disp_de, cfg.top_row_flip, cfg.bottom_row_flip, cfg.mult_sel,
      cfg.temp_coeff_sel});
    chk("volt", 0, {cfg.contrast_level, cfg.vlcd_range_high, cfg.bias_ratio_sel});
    chk("addr", 0, {1'b0, bank_addr, col_addr});
    chk("mode", LCDC_BLANK, disp_mode);
    chk("pwr", 12'h010, {lcd_outputs_off, osc_enable, bias_gen_en, vlcd_gen_en,
      charge_pump_en});
    chk("mult", 2, mult_factor);
    chk("bias", 7, bias_n);
    chk("wr_en", 0, ram_wr.wr_en);
    chk("drv_row", 0, drv_row);
  endtask
  // ****************************************
  // watchdog
  // ****************************************
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    give_verdict();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 32'h0000_a318;
    mismatches = 0;
    total_checks = 0;
    rst = 1'b1;
    ext_clk_sel = 1'b0;
    scan_row = 7'h00;
    repeat (4) @(posedge ref_clk);
    #2;
    rst = 1'b0;
    chk_reset();
    u_host.send(1'b0, 8'h20);
    u_host.rest();
    chk("pwr", 12'h00e, {lcd_outputs_off, osc_enable, bias_gen_en, vlcd_gen_en,
      charge_pump_en});
    ext_clk_sel = 1'b1;
    repeat (4) u_host.rest();
    chk("osc", 0, osc_enable);
    ext_clk_sel = 1'b0;
    repeat (4) u_host.rest();
    chk("osc", 1, osc_enable);
    for (i = 0; i < 4; i++) begin
      u_host.send(1'b0, {5'h01, i[1], 1'b0, i[0]});
      u_host.rest();
      chk("disp_de", i, cfg.disp_de);
      chk("disp_mode", exp_mode(i[1:0]), disp_mode);
    end
    for (i = 0; i < 4; i++) begin
      u_host.send(1'b0, {6'h04, i[1:0]});
      u_host.rest();
      chk("mult", 2 + i, mult_factor);
    end
    for (i = 1; i >= 0; i--) begin
      u_host.send(1'b0, {7'h02, i[0]});
      u_host.rest();
      chk("pump", {i[0], i[0]}, {cfg.vlcd_range_high, charge_pump_en});
    end
    u_host.send(1'b0, 8'h48);
    u_host.send(1'b0, 8'he5);
    chk("addr", 12'h465, {1'b0, bank_addr, col_addr});
    wr_chk(4'h8, 7'h65, 8'h7f);
    wr_chk(4'h0, 7'h00, 8'hc3);
    u_host.rest();
    chk("pulse", 0, ram_wr.wr_en);
    u_host.send(1'b0, 8'h49);
    u_host.send(1'b1, 8'h11);
    chk("oob_wr", 0, ram_wr.wr_en);
    chk("oob_addr", 12'h481, {1'b0, bank_addr, col_addr});
    u_host.send(1'b0, 8'h22);
    u_host.send(1'b0, 8'h48);
    u_host.send(1'b0, 8'h85);
    wr_chk(4'h8, 7'h05, 8'h96);
    wr_chk(4'h0, 7'h06, 8'h69);
    u_host.send(1'b0, 8'h20);
    for (i = 0; i < 20; i++) begin
      rb = 4'({$random(seed)} % 9);
      rc = 7'({$random(seed)} % 102);
      r = 8'($random(seed));
      u_host.send(1'b0, {4'h4, rb});
      u_host.send(1'b0, {1'b1, rc});
      wr_chk(rb, rc, r);
    end
    u_host.send(1'b0, 8'h40);
    u_host.send(1'b0, 8'h8a);
    u_host.send(1'b0, 8'h24);
    wr_chk(4'h0, 7'h0a, 8'h5a);
    u_host.rest();
    chk("pwr", 12'h010, {lcd_outputs_off, osc_enable, bias_gen_en, vlcd_gen_en,
      charge_pump_en});
    u_host.send(1'b0, 8'h21);
    u_host.send(1'b0, 8'h43);
    chk("ext_bank", 0, bank_addr);
    wr_chk(4'h0, 7'h0b, 8'h3c);
    for (i = 0; i < 8; i++) begin
      u_host.send(1'b0, {5'h02, i[2:0]});
      u_host.rest();
      chk("bias", 7 - i, bias_n);
      chk("mult", 5, mult_factor);
    end
    for (i = 0; i < 4; i++) begin
      u_host.send(1'b0, {6'h01, i[1:0]});
      chk("temp", i, cfg.temp_coeff_sel);
    end
    for (i = 0; i < 6; i++) begin
      r = (i == 0) ? 8'h00 : (i == 1) ? 8'h7f : 8'($random(seed));
      u_host.send(1'b0, {1'b1, r[6:0]});
      u_host.rest();
      chk("contrast", r[6:0], cfg.contrast_level);
      chk("pump", r[6:0] != 7'h00, charge_pump_en);
      chk("col", 7'h0c, col_addr);
    end
    for (i = 0; i < 16; i++) begin
      u_host.send(1'b0, {4'h2, i[3], 3'h1});
      u_host.send(1'b0, {5'h01, i[2:0]});
      for (j = 0; j < 6; j++) begin
        scan_row = (j == 0) ? 7'h13 : (j == 1) ? 7'h40 : 7'({$random(seed)} % 65);
        u_host.rest();
        chk("drv_row", exp_row(scan_row, i[3], i[1], i[0]), drv_row);
      end
    end
    // column flip on, then the host rewrites the columns it wants mirrored
    u_host.send(1'b0, 8'h30);
    u_host.send(1'b0, 8'h42);
    u_host.send(1'b0, 8'h83);
    wr_chk(4'h2, 7'h61, 8'ha5);
    wr_chk(4'h2, 7'h60, 8'h5a);
    u_host.send(1'b0, 8'he5);
    wr_chk(4'h2, 7'h65, 8'h11);
    wr_chk(4'h3, 7'h64, 8'h22);
    // reset in mid-run must undo every setting made above
    rst = 1'b1;
    u_host.rest();
    rst = 1'b0;
    chk_reset();
    u_host.send(1'b0, 8'h20);
    u_host.rest();
    chk("pwr", 12'h00e, {lcd_outputs_off, osc_enable, bias_gen_en, vlcd_gen_en,
      charge_pump_en});
    give_verdict();
  end
endmodule // lcdc_decode_tb_top
`default_nettype wire

// [dv/lcdc_host_model.sv]
// lcdc_host_model: host side that feeds command and data bytes
// assumes: driven by task calls from the bench, one byte per ref_clk edge
`timescale 1ns/1ns
`default_nettype none
module lcdc_host_model (
  input wire logic ref_clk,
  output logic cmd_valid,
  output logic cmd_is_data,
  output logic [7:0] cmd_byte
);
  initial begin
    cmd_valid = 1'b0;
    cmd_is_data = 1'b0;
    cmd_byte = 8'h00;
  end
  // valid stays up so that bytes can follow back to back
  task automatic send(input logic is_data, input logic [7:0] b);
    cmd_valid = 1'b1;
    cmd_is_data = is_data;
    cmd_byte = b;
    @(posedge ref_clk);
    #2;
  endtask
  // idle lines show the inverse of the last value, so two rests in a row show the sent byte again
  task automatic rest();
    cmd_valid = 1'b0;
    cmd_is_data = ~cmd_is_data;
    cmd_byte = ~cmd_byte;
    @(posedge ref_clk);
    #2;
  endtask
endmodule // lcdc_host_model
`default_nettype wire

// [rtl/lcdc_cfg.svh]
// lcdc_cfg.svh: command codes, field positions, limits and reset values
// assumes: included by bare name inside rtl files of the lcdc block
`ifndef LCDC_CFG_SVH
`define LCDC_CFG_SVH
// command byte masks and match values
`define LCDC_FSET_MASK 8'hE0
`define LCDC_FSET_VAL 8'h20
`define LCDC_XADR_MASK 8'h80
`define LCDC_XADR_VAL 8'h80
`define LCDC_YADR_MASK 8'hF0
`define LCDC_YADR_VAL 8'h40
`define LCDC_STG_MASK 8'hFC
`define LCDC_STG_VAL 8'h10
`define LCDC_DCTL_MASK 8'hFA
`define LCDC_DCTL_VAL 8'h08
`define LCDC_RNG_MASK 8'hFE
`define LCDC_RNG_VAL 8'h04
`define LCDC_CONTR_MASK 8'h80
`define LCDC_CONTR_VAL 8'h80
`define LCDC_BIAS_MASK 8'hF8
`define LCDC_BIAS_VAL 8'h10
`define LCDC_DCFG_MASK 8'hF8
`define LCDC_DCFG_VAL 8'h08
`define LCDC_TEMP_MASK 8'hFC
`define LCDC_TEMP_VAL 8'h04
// field positions in a command byte
`define LCDC_FS_SLEEP 2
`define LCDC_FS_VERT 1
`define LCDC_FS_PAGE 0
`define LCDC_FS_COLF 4
`define LCDC_FS_ROWF 3
`define LCDC_DC_D 2
`define LCDC_DC_E 0
`define LCDC_CF_ORDER 2
`define LCDC_CF_TOP 1
`define LCDC_CF_BOT 0
// address limits
`define LCDC_BANK_MAX 4'h8
`define LCDC_COL_MAX 7'h65
`define LCDC_COL_MIRROR 7'h64
`define LCDC_BANK8_MASK 8'h80
`define LCDC_ROW_LAST 7'h40
`define LCDC_TOP_A_LO 7'h13
`define LCDC_TOP_A_HI 7'h20
`define LCDC_TOP_B_LO 7'h33
`define LCDC_TOP_B_HI 7'h40
`define LCDC_BOT_A_LO 7'h00
`define LCDC_BOT_A_HI 7'h12
`define LCDC_BOT_B_LO 7'h21
`define LCDC_BOT_B_HI 7'h32
// reset values and value bases
`define LCDC_RST_SLEEP 1'b1
`define LCDC_RST_PWR 5'h08
`define LCDC_MULT_BASE 3'h2
`define LCDC_BIAS_TOP 3'h7
`endif

// [rtl/lcdc_decode.sv]
// lcdc_decode: command decoder and configuration state of the lcd driver
// assumes: command bytes arrive on ref_clk from the host interface logic
// What this block does
// R1: sleep grounds outputs, stops bias and vlcd generators, ram still writable.
// R2: sleep stops the internal oscillator; an external clock keeps logic running.
// R3: order bit 0 steps horizontally, 1 steps vertically.
// R4: basic page executes display control, stages, bank and column commands.
// R5: extended page executes extended commands instead of basic ones.
// R6: data write and function set execute on either page.
// R7: column flip 1 reverses column placement of later writes.
// R8: host rewrites ram after changing column flip to mirror the picture.
// R9: row flip mirrors the picture vertically at once.
// R10: two display-mode bits select the active display mode.
// R11: top-row flip reverses drivers 19-32 and 51-64.
// R12: bottom-row flip reverses drivers 0-18 and 33-50.
// R13: four-bit bank index picks bank 0 to 8, columns 0 to 101.
// R14: bank 8 stores only the data byte's top bit.
// R15: column index accepts 0 to 101 (0x65).
// R16: multiplier resets to factor two; others only by stages command.
// R17: two-bit field picks one of four temperature coefficients.
// R18: bias factor n equals 7 minus the bias field.
// R19: range bit picks low or high voltage offset, same step.
// R20: seven-bit contrast code, each step one fixed voltage increment.
// R21: charge pump off while contrast code and range bit are zero.
// R22: mode pair 00 blank, 10 normal, 01 all on, 11 inverse.
// R23: reset clears addresses, horizontal, basic page, no mirror, blank, sleep.
// R24: writes to bank above 8 or column above 101 are ignored.
`timescale 1ns/1ns
`default_nettype none
`include "lcdc_cfg.svh"
module lcdc_decode
  import lcdc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_is_data,
  input wire logic [7:0] cmd_byte,
  input wire logic ext_clk_sel,
  input wire logic [6:0] scan_row,
  output lcdc_cfg_t cfg,
  output lcdc_mode_t disp_mode,
  output lcdc_ramwr_t ram_wr,
  output logic [3:0] bank_addr,
  output logic [6:0] col_addr,
  output logic [6:0] drv_row,
  output logic osc_enable,
  output logic lcd_outputs_off,
  output logic bias_gen_en,
  output logic vlcd_gen_en,
  output logic charge_pump_en,
  output logic [2:0] mult_factor,
  output logic [2:0] bias_n
);

  // ****************************************
  // state
  // ****************************************
  lcdc_cfg_t cfg_reg, cfg_next;
  lcdc_ramwr_t wr_reg, wr_next;
  logic [3:0] yadr_reg, yadr_next;
  logic [6:0] xadr_reg, xadr_next;
  logic [6:0] row_reg, row_next;
  lcdc_mode_t mode_reg, mode_next;
  logic [4:0] pwr_reg, pwr_next;
  logic [2:0] mult_reg, mult_next;
  logic [2:0] bias_reg, bias_next;
  logic ext_clk_sync;
  logic [6:0] row_map;
  logic in_range;
  logic [6:0] phys_col;

  lcdc_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .d(ext_clk_sel),
    .q(ext_clk_sync)
  );

  lcdc_row_map u_row_map (
    .row(scan_row),
    .row_flip(cfg_reg.row_flip),
    .top_row_flip(cfg_reg.top_row_flip),
    .bottom_row_flip(cfg_reg.bottom_row_flip),
    .drv(row_map)
  );

  // ****************************************
  // command decode and address stepping
  // ****************************************
  always_comb begin
    cfg_next = cfg_reg;
    yadr_next = yadr_reg;
    xadr_next = xadr_reg;
    wr_next = wr_reg;
    wr_next.wr_en = 1'b0;
    // R13: bank and column bounds; R15: column up to 0x65
    in_range = (yadr_reg <= `LCDC_BANK_MAX) && (xadr_reg <= `LCDC_COL_MAX);
    // R7: mirrored column placement
    phys_col = (cfg_reg.column_flip && xadr_reg <= `LCDC_COL_MIRROR) ?
      7'(`LCDC_COL_MIRROR - xadr_reg) : xadr_reg;
    if (cmd_valid && cmd_is_data) begin
      // R6: data accepted on either page; R1: also while asleep
      // R24: out-of-range writes dropped
      if (in_range) begin
        wr_next.wr_en = 1'b1;
        wr_next.bank = yadr_reg;
        wr_next.col = phys_col;
        wr_next.data = cmd_byte;
        // R14: bank 8 keeps only the top bit
        wr_next.mask = (yadr_reg == `LCDC_BANK_MAX) ? `LCDC_BANK8_MASK : 8'hFF;
        // R3: stepping order
        if (!cfg_reg.addr_vertical) begin
          if (xadr_reg == `LCDC_COL_MAX) begin
            xadr_next = 7'h00;
            yadr_next = (yadr_reg == `LCDC_BANK_MAX) ? 4'h0 : yadr_reg + 4'h1;
          end else begin
            xadr_next = xadr_reg + 7'h01;
          end
        end else begin
          if (yadr_reg == `LCDC_BANK_MAX) begin
            yadr_next = 4'h0;
            xadr_next = (xadr_reg == `LCDC_COL_MAX) ? 7'h00 : xadr_reg + 7'h01;
          end else begin
            yadr_next = yadr_reg + 4'h1;
          end
        end
      end
    end else if (cmd_valid) begin
      // R6: function set on either page
      if ((cmd_byte & `LCDC_FSET_MASK) == `LCDC_FSET_VAL) begin
        cfg_next.sleep_flag = cmd_byte[`LCDC_FS_SLEEP];
        cfg_next.addr_vertical = cmd_byte[`LCDC_FS_VERT];
        cfg_next.ext_page = cmd_byte[`LCDC_FS_PAGE];
        // R7: column flip; R9: row flip
        cfg_next.column_flip = cmd_byte[`LCDC_FS_COLF];
        cfg_next.row_flip = cmd_byte[`LCDC_FS_ROWF];
      end else if (!cfg_reg.ext_page) begin
        // R4: basic page commands
        if ((cmd_byte & `LCDC_XADR_MASK) == `LCDC_XADR_VAL) begin
          xadr_next = cmd_byte[6:0];
        end else if ((cmd_byte & `LCDC_YADR_MASK) == `LCDC_YADR_VAL) begin
          yadr_next = cmd_byte[3:0];
        end else if ((cmd_byte & `LCDC_STG_MASK) == `LCDC_STG_VAL) begin
          // R16: multiplier changes only here
          cfg_next.mult_sel = cmd_byte[1:0];
        end else if ((cmd_byte & `LCDC_DCTL_MASK) == `LCDC_DCTL_VAL) begin
          // R10: display mode pair
          cfg_next.disp_de = {cmd_byte[`LCDC_DC_D], cmd_byte[`LCDC_DC_E]};
        end else if ((cmd_byte & `LCDC_RNG_MASK) == `LCDC_RNG_VAL) begin
          // R19: voltage range select
          cfg_next.vlcd_range_high = cmd_byte[0];
        end
      end else begin
        // R5: extended page commands
        if ((cmd_byte & `LCDC_CONTR_MASK) == `LCDC_CONTR_VAL) begin
          // R20: contrast code
          cfg_next.contrast_level = cmd_byte[6:0];
        end else if ((cmd_byte & `LCDC_BIAS_MASK) == `LCDC_BIAS_VAL) begin
          cfg_next.bias_ratio_sel = cmd_byte[2:0];
        end else if ((cmd_byte & `LCDC_DCFG_MASK) == `LCDC_DCFG_VAL) begin
          // R11, R12: top and bottom row flip bits act through the row map, reaching drv_row one cycle after cfg
          cfg_next.lsb_on_top = cmd_byte[`LCDC_CF_ORDER];
          cfg_next.top_row_flip = cmd_byte[`LCDC_CF_TOP];
          cfg_next.bottom_row_flip = cmd_byte[`LCDC_CF_BOT];
        end else if ((cmd_byte & `LCDC_TEMP_MASK) == `LCDC_TEMP_VAL) begin
          // R17: temperature coefficient
          cfg_next.temp_coeff_sel = cmd_byte[1:0];
        end
      end
    end
  end

  // ****************************************
  // derived outputs
  // ****************************************
  always_comb begin
    row_next = row_map;
    // R22: mode pair decode
    case (cfg_reg.disp_de)
      2'b10: mode_next = LCDC_NORMAL;
      2'b01: mode_next = LCDC_ALL_ON;
      2'b11: mode_next = LCDC_INVERSE;
      default: mode_next = LCDC_BLANK;
    endcase
    // R1: sleep grounds outputs and stops generators
    // R2: oscillator stopped in sleep or when an external clock is used
    // R21: charge pump off on zero code and low range
    pwr_next = {!cfg_reg.sleep_flag && !ext_clk_sync,
      cfg_reg.sleep_flag,
      !cfg_reg.sleep_flag,
      !cfg_reg.sleep_flag,
      !cfg_reg.sleep_flag && (cfg_reg.contrast_level != 7'h00 || cfg_reg.vlcd_range_high)};
    // R16: factor is two plus the stage field
    mult_next = `LCDC_MULT_BASE + {1'b0, cfg_reg.mult_sel};
    // R18: n is seven minus the bias field
    bias_next = `LCDC_BIAS_TOP - cfg_reg.bias_ratio_sel;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      // R23: reset state
      cfg_reg <= '0;
      cfg_reg.sleep_flag <= `LCDC_RST_SLEEP;
      wr_reg <= '0;
      yadr_reg <= 4'h0;
      xadr_reg <= 7'h00;
      row_reg <= 7'h00;
      mode_reg <= LCDC_BLANK;
      pwr_reg <= `LCDC_RST_PWR;
      mult_reg <= `LCDC_MULT_BASE;
      bias_reg <= `LCDC_BIAS_TOP;
    end else begin
      cfg_reg <= cfg_next;
      wr_reg <= wr_next;
      yadr_reg <= yadr_next;
      xadr_reg <= xadr_next;
      row_reg <= row_next;
      mode_reg <= mode_next;
      pwr_reg <= pwr_next;
      mult_reg <= mult_next;
      bias_reg <= bias_next;
    end
  end

  assign cfg = cfg_reg;
  assign disp_mode = mode_reg;
  assign ram_wr = wr_reg;
  assign bank_addr = yadr_reg;
  assign col_addr = xadr_reg;
  assign drv_row = row_reg;
  assign osc_enable = pwr_reg[4];
  assign lcd_outputs_off = pwr_reg[3];
  assign bias_gen_en = pwr_reg[2];
  assign vlcd_gen_en = pwr_reg[1];
  assign charge_pump_en = pwr_reg[0];
  assign mult_factor = mult_reg;
  assign bias_n = bias_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic fset_cmd;
  assign fset_cmd = cmd_valid && !cmd_is_data &&
    ((cmd_byte & `LCDC_FSET_MASK) == `LCDC_FSET_VAL);

  sleep_outputs_a: assert property (cfg.sleep_flag |=> lcd_outputs_off && !bias_gen_en // R1
    && !vlcd_gen_en && !charge_pump_en) else $error("sleep did not ground outputs");
  osc_stop_a: assert property (cfg.sleep_flag |=> !osc_enable) // R2
    else $error("oscillator running in sleep");
  order_bit_a: assert property (fset_cmd |=> cfg.addr_vertical == $past(cmd_byte[1])) // R3
    else $error("order bit not taken");
  basic_guard_a: assert property (cmd_valid && !cmd_is_data && cfg.ext_page // R4
    && cmd_byte[7:4] == 4'h4 |=> $stable(bank_addr)) else $error("bank set on extended page");
  ext_guard_a: assert property (cmd_valid && !cmd_is_data && !cfg.ext_page // R5
    && cmd_byte[7] |=> $stable(cfg.contrast_level)) else $error("contrast set on basic page");
  fset_any_a: assert property (fset_cmd |=> cfg.sleep_flag == $past(cmd_byte[2]) // R6
    && cfg.ext_page == $past(cmd_byte[0])) else $error("function set missed");
  col_mirror_a: assert property (cmd_valid && cmd_is_data && cfg.column_flip // R7
    && col_addr <= 7'h64 && bank_addr <= 4'h8 |=> ram_wr.wr_en
    && ram_wr.col == 7'h64 - $past(col_addr))
    else $error("mirrored column wrong");
  bank8_mask_a: assert property (ram_wr.wr_en && ram_wr.bank == 4'h8 // R14
    |-> ram_wr.mask == 8'h80) else $error("bank 8 mask wrong");
  mult_value_a: assert property (##1 mult_factor == 3'h2 + {1'b0, $past(cfg.mult_sel)}) // R16
    else $error("multiplier factor wrong");
  bias_value_a: assert property (##1 bias_n == 3'h7 - $past(cfg.bias_ratio_sel)) // R18
    else $error("bias factor wrong");
  pump_off_a: assert property (cfg.contrast_level == 7'h00 && !cfg.vlcd_range_high // R21
    |=> !charge_pump_en) else $error("charge pump left on");
  range_drop_a: assert property (cmd_valid && cmd_is_data // R24
    && (bank_addr > 4'h8 || col_addr > 7'h65) |=> !ram_wr.wr_en && $stable(col_addr))
    else $error("out of range write taken");
  osc_wake_a: assert property (!cfg.sleep_flag && !ext_clk_sync |=> osc_enable) // R2
    else $error("oscillator stopped while awake");
  row_flip_a: assert property (cfg.row_flip && !cfg.top_row_flip && !cfg.bottom_row_flip // R9
    && scan_row <= 7'h40 |=> drv_row == 7'h40 - $past(scan_row))
    else $error("row flip not mirrored");
  mode_normal_a: assert property (cfg.disp_de == 2'b10 |=> disp_mode == LCDC_NORMAL) // R22
    else $error("normal mode pair not decoded");
  mode_all_on_a: assert property (cfg.disp_de == 2'b01 |=> disp_mode == LCDC_ALL_ON) // R22
    else $error("all on pair not decoded");
  bank_step_a: assert property (cmd_valid && cmd_is_data && !cfg.addr_vertical // R13
    && col_addr == 7'h65 && bank_addr < 4'h8 |=> bank_addr == $past(bank_addr) + 4'h1
    && col_addr == 7'h00) else $error("horizontal wrap wrong");
  temp_sel_a: assert property (cmd_valid && !cmd_is_data && cfg.ext_page // R17
    && cmd_byte[7:2] == 6'h01 |=> cfg.temp_coeff_sel == $past(cmd_byte[1:0]))
    else $error("temperature coefficient not taken");
  contrast_set_a: assert property (cmd_valid && !cmd_is_data && cfg.ext_page // R20
    && cmd_byte[7] |=> cfg.contrast_level == $past(cmd_byte[6:0]))
    else $error("contrast code not taken");

  wake_c: cover property (fset_cmd && !cmd_byte[2] ##1 !cfg.sleep_flag);
  bank8_c: cover property (ram_wr.wr_en && ram_wr.bank == 4'h8);
  inverse_c: cover property (disp_mode == LCDC_INVERSE);
  vert_wrap_c: cover property (cfg.addr_vertical && ram_wr.wr_en && ram_wr.bank == 4'h8);
  col_flip_c: cover property (cfg.column_flip && ram_wr.wr_en);

endmodule // lcdc_decode
`default_nettype wire

// [rtl/lcdc_pkg.sv]
// lcdc_pkg: types shared by the lcdc design files
// assumes: nothing beyond the compile order
package lcdc_pkg;
  typedef enum logic [1:0] {LCDC_BLANK, LCDC_NORMAL, LCDC_ALL_ON, LCDC_INVERSE} lcdc_mode_t;
  typedef struct packed {
    logic sleep_flag;
    logic addr_vertical;
    logic ext_page;
    logic column_flip;
    logic row_flip;
    logic [1:0] disp_de;
    logic top_row_flip;
    logic bottom_row_flip;
    logic lsb_on_top;
    logic [1:0] mult_sel;
    logic [1:0] temp_coeff_sel;
    logic [2:0] bias_ratio_sel;
    logic [6:0] contrast_level;
    logic vlcd_range_high;
  } lcdc_cfg_t;
  typedef struct packed {
    logic wr_en;
    logic [3:0] bank;
    logic [6:0] col;
    logic [7:0] data;
    logic [7:0] mask;
  } lcdc_ramwr_t;
endpackage

// [rtl/lcdc_row_map.sv]
// lcdc_row_map: maps a scan row to its row driver index
// assumes: row is 0 to 64; result is combinational
`timescale 1ns/1ns
`default_nettype none
`include "lcdc_cfg.svh"
module lcdc_row_map (
  input wire logic [6:0] row,
  input wire logic row_flip,
  input wire logic top_row_flip,
  input wire logic bottom_row_flip,
  output logic [6:0] drv
);
  logic [6:0] r;
  always_comb begin
    // R9: vertical mirror
    r = row_flip ? 7'(`LCDC_ROW_LAST - row) : row;
    drv = r;
    // R11: top pad blocks reversed
    if (top_row_flip && r >= `LCDC_TOP_A_LO && r <= `LCDC_TOP_A_HI) begin
      drv = 7'(`LCDC_TOP_A_LO + `LCDC_TOP_A_HI - r);
    end
    if (top_row_flip && r >= `LCDC_TOP_B_LO && r <= `LCDC_TOP_B_HI) begin
      drv = 7'(`LCDC_TOP_B_LO + `LCDC_TOP_B_HI - r);
    end
    // R12: bottom pad blocks reversed
    if (bottom_row_flip && r <= `LCDC_BOT_A_HI) begin
      drv = 7'(`LCDC_BOT_A_LO + `LCDC_BOT_A_HI - r);
    end
    if (bottom_row_flip && r >= `LCDC_BOT_B_LO && r <= `LCDC_BOT_B_HI) begin
      drv = 7'(`LCDC_BOT_B_LO + `LCDC_BOT_B_HI - r);
    end
  end
endmodule // lcdc_row_map
`default_nettype wire

// [rtl/lcdc_sync.sv]
// lcdc_sync: two-flop synchroniser for one level
// assumes: d is asynchronous to ref_clk
`timescale 1ns/1ns
`default_nettype none
module lcdc_sync (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic meta_reg;
  logic sync_reg;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end
  assign q = sync_reg;
endmodule // lcdc_sync
`default_nettype wire
